/* logic/logic_cell_regs.vh */
// Register map and configuration layout of the adaptive logic cell
`ifndef LOGIC_CELL_REGS_VH
`define LOGIC_CELL_REGS_VH

// Register byte offsets
`define ADDR_CONFIG 8'h00
`define ADDR_LUT_UPPER_LO 8'h04
`define ADDR_LUT_UPPER_HI 8'h08
`define ADDR_LUT_LOWER_LO 8'h0C
`define ADDR_LUT_LOWER_HI 8'h10
`define ADDR_ROUTE 8'h14
`define ADDR_STATUS 8'h18
`define ADDR_CELL_IN 8'h1C
`define ADDR_CTRL 8'h20

// Fields of the configuration register
`define CFG_MODE_LSB 0
`define CFG_MODE_MSB 2
`define CFG_LOCK_BIT 3
`define CFG_RESET_VALUE 32'h00000000

// Mode encodings
`define MODE_NORMAL 3'h0
`define MODE_EXT_LUT 3'h1
`define MODE_ARITH 3'h2
`define MODE_SHARED_ARITH 3'h3
`define MODE_LUT_REG 3'h4

// Fields of the route register
`define RT_UPPER_REG_BIT 0
`define RT_LOWER_REG_BIT 1
`define RT_UPPER_SRC_BIT 2
`define RT_LOWER_SRC_BIT 3
`define RT_FEEDBACK_UPPER_BIT 4
`define RT_FEEDBACK_LOWER_BIT 5
`define RT_PACK_UPPER_BIT 6
`define RT_PACK_LOWER_BIT 7
`define RT_SCLR_EN0_BIT 8
`define RT_SCLR_EN1_BIT 9
`define RT_SLOAD_EN0_BIT 10
`define RT_SLOAD_EN1_BIT 11
`define RT_SIX_UPPER_BIT 12
`define RT_SIX_LOWER_BIT 13
`define RT_COUNTER_BIT 14
`define RT_RESET_VALUE 32'h00000000

// Fields of the control register
`define CTRL_ACLR_BIT 0
`define CTRL_SCLR_BIT 1
`define CTRL_SLOAD_BIT 2
`define CTRL_ENA_BIT 3
`define CTRL_RESET_VALUE 32'h00000008

// AXI4-Lite responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* logic/logic_cell.v */
// Adaptive logic cell: two lookups, two adders, two flops and a LUT register, AXI4-Lite configuration
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "logic_cell_regs.vh"

module logic_cell #(
  parameter ADDR_WIDTH = 8
) (
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite slave
  input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Cell data inputs from cluster routing
  input wire data_a,
  input wire data_b,
  input wire data_c,
  input wire data_d,
  input wire in_e_upper,
  input wire in_f_upper,
  input wire in_e_lower,
  input wire in_f_lower,
  input wire carry_in,
  input wire shared_in,
  input wire chain_in,
  // Cluster-wide controls
  input wire cluster_ena,
  input wire cluster_aclr,
  input wire cluster_sclr,
  input wire cluster_sload,
  // Output sets
  output reg upper_route_a,
  output reg upper_route_b,
  output reg lower_route_a,
  output reg lower_route_b,
  output reg carry_out,
  output reg shared_out,
  output reg chain_out
);

  // ==========================================================
  // Configuration registers
  // ==========================================================
  reg [31:0] config_reg;
  reg [31:0] lut_upper_lo;
  reg [31:0] lut_upper_hi;
  reg [31:0] lut_lower_lo;
  reg [31:0] lut_lower_hi;
  reg [31:0] route;
  reg [31:0] ctrl;
  reg first_flop;
  reg second_flop;
  reg lut_reg;
  reg lut_reg_master;

  wire [2:0] mode = config_reg[`CFG_MODE_MSB:`CFG_MODE_LSB];
  wire locked = config_reg[`CFG_LOCK_BIT];
  wire [63:0] upper_table = {lut_upper_hi, lut_upper_lo};
  wire [63:0] lower_table = {lut_lower_hi, lut_lower_lo};

  // ==========================================================
  // AXI4-Lite write path
  // ==========================================================
  reg aw_held;
  reg w_held;
  reg [ADDR_WIDTH-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  wire aw_now = aw_held || s_axi_awvalid;
  wire w_now = w_held || s_axi_wvalid;
  wire [ADDR_WIDTH-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire wr_go = aw_now && w_now && !s_axi_bvalid;

  function [31:0] merge;
    input [31:0] old_value;
    input [31:0] new_value;
    input [3:0] strb;
    integer i;
    begin
      merge = old_value;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = new_value[i*8 +: 8];
        end
      end
    end
  endfunction

  reg wr_ok;
  always @* begin
    case (wr_addr[7:0])
      `ADDR_CONFIG, `ADDR_LUT_UPPER_LO, `ADDR_LUT_UPPER_HI, `ADDR_LUT_LOWER_LO,
      `ADDR_LUT_LOWER_HI, `ADDR_ROUTE, `ADDR_CTRL: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Static tables and routing are frozen while locked
  wire static_wr = wr_go && !locked;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {ADDR_WIDTH{1'b0}};
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      config_reg <= `CFG_RESET_VALUE;
      lut_upper_lo <= 32'h00000000;
      lut_upper_hi <= 32'h00000000;
      lut_lower_lo <= 32'h00000000;
      lut_lower_hi <= 32'h00000000;
      route <= `RT_RESET_VALUE;
      ctrl <= `CTRL_RESET_VALUE;
    end else begin
      if (s_axi_awvalid && s_axi_awready && !w_now) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !aw_now) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_addr[7:0] == `ADDR_CTRL) begin
          ctrl <= merge(ctrl, wr_data, wr_strb);
        end
        if (wr_addr[7:0] == `ADDR_CONFIG) begin
          if (!locked) begin
            config_reg <= merge(config_reg, wr_data, wr_strb);
          end else begin
            config_reg[`CFG_LOCK_BIT] <= !(wr_strb[0] && !wr_data[`CFG_LOCK_BIT]);
          end
        end
      end
      if (static_wr) begin
        case (wr_addr[7:0])
          `ADDR_LUT_UPPER_LO: lut_upper_lo <= merge(lut_upper_lo, wr_data, wr_strb);
          `ADDR_LUT_UPPER_HI: lut_upper_hi <= merge(lut_upper_hi, wr_data, wr_strb);
          `ADDR_LUT_LOWER_LO: lut_lower_lo <= merge(lut_lower_lo, wr_data, wr_strb);
          `ADDR_LUT_LOWER_HI: lut_lower_hi <= merge(lut_lower_hi, wr_data, wr_strb);
          `ADDR_ROUTE: route <= merge(route, wr_data, wr_strb);
          default: ;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  // ==========================================================
  assign s_axi_arready = !s_axi_rvalid;

  wire [31:0] status = {25'h0000000, lut_reg, carry_out, shared_out,
                        second_flop, first_flop, locked, mode == `MODE_ARITH};
  wire [31:0] cell_in = {21'h000000, chain_in, shared_in, carry_in, in_f_lower,
                         in_e_lower, in_f_upper, in_e_upper, data_d, data_c,
                         data_b, data_a};

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      case (s_axi_araddr[7:0])
        `ADDR_CONFIG: s_axi_rdata <= config_reg;
        `ADDR_LUT_UPPER_LO: s_axi_rdata <= lut_upper_lo;
        `ADDR_LUT_UPPER_HI: s_axi_rdata <= lut_upper_hi;
        `ADDR_LUT_LOWER_LO: s_axi_rdata <= lut_lower_lo;
        `ADDR_LUT_LOWER_HI: s_axi_rdata <= lut_lower_hi;
        `ADDR_ROUTE: s_axi_rdata <= route;
        `ADDR_STATUS: s_axi_rdata <= status;
        `ADDR_CELL_IN: s_axi_rdata <= cell_in;
        `ADDR_CTRL: s_axi_rdata <= ctrl;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Input steering and lookups
  // ==========================================================
  // Register feedback replaces the fourth shared input of a half
  wire d_upper = route[`RT_FEEDBACK_UPPER_BIT] ? first_flop : data_d;
  wire d_lower = route[`RT_FEEDBACK_LOWER_BIT] ? second_flop : data_d;
  // Each half's six-input function keeps its own e/f and output path
  wire [5:0] upper_idx = {in_f_upper, in_e_upper, d_upper, data_c, data_b, data_a};
  wire [5:0] lower_idx = {in_f_lower, in_e_lower, d_lower, data_c, data_b, data_a};
  wire upper_lut6 = upper_table[upper_idx];
  wire lower_lut6 = lower_table[lower_idx];
  // Extended: two five-input functions sharing a..d, picked by f_upper
  wire [4:0] ext_idx = {in_e_upper, d_upper, data_c, data_b, data_a};
  wire ext_lo = upper_table[{1'b0, ext_idx}];
  wire ext_hi = lower_table[{1'b0, in_e_lower, d_upper, data_c, data_b, data_a}];
  wire ext_out = in_f_upper ? ext_hi : ext_lo;

  // Arithmetic: four four-input lookups sharing a and b
  wire [3:0] ar_idx_u = {in_e_upper, data_c, data_b, data_a};
  wire [3:0] ar_idx_l = {in_e_lower, d_upper, data_b, data_a};
  wire pre_u0 = upper_table[{2'h0, ar_idx_u}];
  wire pre_u1 = upper_table[{2'h1, ar_idx_u}];
  wire pre_l0 = lower_table[{2'h0, ar_idx_l}];
  wire pre_l1 = lower_table[{2'h1, ar_idx_l}];
  // Counter controls from local inputs: f_upper up/down, f_lower add/sub
  wire counting = route[`RT_COUNTER_BIT];
  wire invert_b = counting ? !in_f_upper : in_f_lower;
  wire b_u = pre_u1 ^ invert_b;
  wire b_l = pre_l1 ^ invert_b;
  wire shared_mode = mode == `MODE_SHARED_ARITH;
  wire first_full_adder_cin = shared_mode ? shared_in : carry_in;
  wire sum0 = pre_u0 ^ b_u ^ first_full_adder_cin;
  wire cout0 = (pre_u0 & b_u) | (first_full_adder_cin & (pre_u0 ^ b_u));
  wire sum1 = pre_l0 ^ b_l ^ cout0;
  wire cout1 = (pre_l0 & b_l) | (cout0 & (pre_l0 ^ b_l));

  // ==========================================================
  // Per-half results
  // ==========================================================
  reg comb_upper;
  reg comb_lower;
  always @* begin
    case (mode)
      `MODE_EXT_LUT: begin
        comb_upper = ext_out;
        comb_lower = 1'b0;
      end
      `MODE_ARITH, `MODE_SHARED_ARITH: begin
        comb_upper = sum0;
        comb_lower = sum1;
      end
      default: begin
        comb_upper = upper_lut6;
        comb_lower = lower_lut6;
      end
    endcase
  end

  // Counter enable on in_f_lower gates flop updates when counting in arithmetic mode
  wire count_en = !(counting && (mode == `MODE_ARITH)) || in_f_lower;
  // Pack path: spare input feeds the flop directly
  wire pack_ok_lower = !route[`RT_SIX_LOWER_BIT] || !route[`RT_LOWER_REG_BIT];
  wire pack_d_lower = (mode == `MODE_EXT_LUT) ? in_f_lower : in_f_upper;
  wire d0 = (route[`RT_PACK_UPPER_BIT] && pack_ok_lower) ? pack_d_lower :
            (mode == `MODE_LUT_REG ? chain_in : comb_upper);
  wire d1 = route[`RT_PACK_LOWER_BIT] ? in_e_upper : comb_lower;
  wire second_live = !(mode == `MODE_EXT_LUT && !route[`RT_UPPER_REG_BIT]);

  // ==========================================================
  // Flops with cluster controls
  // ==========================================================
  wire aclr = cluster_aclr || ctrl[`CTRL_ACLR_BIT];
  wire sclr = cluster_sclr || ctrl[`CTRL_SCLR_BIT];
  wire sload = cluster_sload || ctrl[`CTRL_SLOAD_BIT];
  wire ena = cluster_ena && ctrl[`CTRL_ENA_BIT] && count_en;

  always @(posedge aclk) begin
    if (!aresetn || aclr) begin
      first_flop <= 1'b0;
      second_flop <= 1'b0;
      lut_reg_master <= 1'b0;
      lut_reg <= 1'b0;
    end else if (ena) begin
      if (sclr && route[`RT_SCLR_EN0_BIT]) begin
        first_flop <= 1'b0;
      end else if (sload && route[`RT_SLOAD_EN0_BIT]) begin
        first_flop <= data_c;
      end else begin
        first_flop <= d0;
      end
      if (!second_live) begin
        second_flop <= 1'b0;
      end else if (sclr && route[`RT_SCLR_EN1_BIT]) begin
        second_flop <= 1'b0;
      end else if (sload && route[`RT_SLOAD_EN1_BIT]) begin
        second_flop <= data_c;
      end else begin
        second_flop <= d1;
      end
      // Third storage element shares clock, enable and the aclr clear, sampled on the rising edge, with the first
      if (mode == `MODE_LUT_REG) begin
        lut_reg_master <= data_d;
        lut_reg <= lut_reg_master;
      end
    end
  end

  // ==========================================================
  // Output sets
  // ==========================================================
  wire upper_sel = route[`RT_UPPER_REG_BIT] ? first_flop : comb_upper;
  wire lower_sel = route[`RT_LOWER_REG_BIT] ? second_flop : comb_lower;
  wire arith = mode == `MODE_ARITH;
  // Carry-with-logic: b outputs carry raw lookup values, sum ignored
  wire upper_b_src = (arith && route[`RT_UPPER_SRC_BIT]) ? upper_lut6 :
                     (mode == `MODE_LUT_REG ? lut_reg : first_flop);
  wire lower_b_src = (arith && route[`RT_LOWER_SRC_BIT]) ? lower_lut6 : comb_lower;

  always @(posedge aclk) begin
    if (!aresetn) begin
      upper_route_a <= 1'b0;
      upper_route_b <= 1'b0;
      lower_route_a <= 1'b0;
      lower_route_b <= 1'b0;
      carry_out <= 1'b0;
      shared_out <= 1'b0;
      chain_out <= 1'b0;
    end else begin
      upper_route_a <= upper_sel;
      upper_route_b <= upper_b_src;
      lower_route_a <= lower_sel;
      lower_route_b <= lower_b_src;
      carry_out <= arith ? cout1 : 1'b0;
      shared_out <= shared_mode ? cout1 : 1'b0;
      chain_out <= second_flop;
    end
  end

endmodule // logic_cell

/* test/cluster_neighbour.sv */
// Model of neighbouring cells and cluster routing feeding the cell inputs
`timescale 1ns/1ps
module cluster_neighbour (
  input wire aclk,
  input wire [10:0] pattern,
  output reg [10:0] pins = 11'h000
);
  // Neighbour outputs are registered, so pins move one edge after a request
  always @(posedge aclk) begin
    pins <= pattern;
  end
endmodule // cluster_neighbour

/* test/logic_cell_asserts.sv */
// Concurrent checks on the logic cell ports
`timescale 1ns/1ps
`include "logic_cell_regs.vh"
module logic_cell_asserts #(
  parameter ADDR_WIDTH = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire upper_route_a,
  input wire carry_out,
  input wire chain_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire wr_taken = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire rd_taken = s_axi_arvalid && s_axi_arready;
  // ==========================================
  // Bus handshakes, unmapped accesses and reset state
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer not held");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer not held");
  property p_wr_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("write taken during answer");
  property p_rd_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rd_block: assert property (p_rd_block) else $error("read taken during answer");
  property p_b_answer;
    wr_taken |=> s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write answer late");
  property p_r_answer;
    rd_taken |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write answer repeated");
  property p_unmapped_rd;
    rd_taken && s_axi_araddr > 8'h20 |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read answered");
  property p_unmapped_wr;
    wr_taken && s_axi_awaddr > 8'h20 |=> s_axi_bresp == `RESP_SLVERR;
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write answered");
  property p_reset_quiet;
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !upper_route_a &&
      !carry_out && !chain_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  c_write: cover property (wr_taken);
  c_read: cover property (rd_taken);
  c_unmapped: cover property (rd_taken && s_axi_araddr > 8'h20);
endmodule // logic_cell_asserts
bind logic_cell logic_cell_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) logic_cell_asserts_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .upper_route_a(upper_route_a), .carry_out(carry_out), .chain_out(chain_out)
);

/* test/logic_cell_tb.sv */
// Self-checking bench for the adaptive logic cell
`timescale 1ns/1ps
`include "logic_cell_regs.vh"
`define CHK(n, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); \
  end \
end
module logic_cell_tb;
  localparam [63:0] NORM_TBL = 64'h17E9D24B8F0C33A5;
  localparam [31:0] EXT_UP = 32'hC3A50F96;
  localparam [31:0] EXT_LO = 32'h5A1EE1B4;
  localparam [1:0] OK = `RESP_OKAY;
  reg aclk;
  reg aresetn;
  reg [7:0] awaddr;
  reg [7:0] araddr;
  reg [31:0] wdata;
  reg awvalid, wvalid, bready, arvalid, rready;
  reg ena, aclr, sclr, sload;
  reg [10:0] pattern;
  wire [10:0] pins;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp;
  wire [1:0] rresp;
  wire [31:0] rdata;
  wire upper_route_a;
  wire lower_route_a;
  wire carry_out;
  integer fails;
  integer checked;
  integer i;
  reg [3:0] nib;
  cluster_neighbour cluster_neighbour_inst (.aclk(aclk), .pattern(pattern), .pins(pins));
  logic_cell logic_cell_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .data_a(pins[0]), .data_b(pins[1]), .data_c(pins[2]), .data_d(pins[3]),
    .in_e_upper(pins[4]), .in_f_upper(pins[5]), .in_e_lower(pins[6]), .in_f_lower(pins[7]),
    .carry_in(pins[8]), .shared_in(pins[9]), .chain_in(pins[10]),
    .cluster_ena(ena), .cluster_aclr(aclr), .cluster_sclr(sclr), .cluster_sload(sload),
    .upper_route_a(upper_route_a), .upper_route_b(), .lower_route_a(lower_route_a),
    .lower_route_b(), .carry_out(carry_out), .shared_out(), .chain_out()
  );
  // ==========================================
  // Bus tasks: handshakes sampled at the falling edge, acted on at the next rising edge
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg t_aw, t_w, t_b;
    reg [1:0] r;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      t_b = 1'b0;
      while (!t_b) begin
        @(negedge aclk);
        t_aw = awvalid && awready;
        t_w = wvalid && wready;
        t_b = bvalid;
        r = bresp;
        @(posedge aclk);
        if (t_aw) awvalid <= 1'b0;
        if (t_w) wvalid <= 1'b0;
        if (t_b) bready <= 1'b0;
      end
      `CHK("bresp", er, r);
    end
  endtask
  task rd(input [7:0] a, input [31:0] m, input [31:0] ed, input [1:0] er);
    reg t_ar, t_r;
    reg [31:0] d;
    reg [1:0] r;
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      t_r = 1'b0;
      while (!t_r) begin
        @(negedge aclk);
        t_ar = arvalid && arready;
        t_r = rvalid;
        d = rdata;
        r = rresp;
        @(posedge aclk);
        if (t_ar) arvalid <= 1'b0;
        if (t_r) rready <= 1'b0;
      end
      `CHK("rresp", er, r);
      `CHK("rdata", ed, d & m);
    end
  endtask
  task setp(input [10:0] p);
    begin
      pattern <= p;
      repeat (4) @(posedge aclk);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // ==========================================
  // Clock, watchdog and tests
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    conclude;
  end
  initial begin
    fails = 0;
    checked = 0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = 0;
    {ena, aclr, sclr, sload, pattern} = {1'b1, 14'h0};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`ADDR_CONFIG, 32'hFFFFFFFF, `CFG_RESET_VALUE, OK);
    rd(`ADDR_ROUTE, 32'hFFFFFFFF, `RT_RESET_VALUE, OK);
    rd(`ADDR_CTRL, 32'hFFFFFFFF, `CTRL_RESET_VALUE, OK);
    rd(8'h40, 32'hFFFFFFFF, 32'h0, `RESP_SLVERR);
    wr(8'h40, 32'h1, `RESP_SLVERR);
    $display("reset and map test done");
    wr(`ADDR_LUT_UPPER_LO, NORM_TBL[31:0], OK);
    wr(`ADDR_LUT_UPPER_HI, NORM_TBL[63:32], OK);
    rd(`ADDR_LUT_UPPER_HI, 32'hFFFFFFFF, NORM_TBL[63:32], OK);
    for (i = 0; i < 8; i = i + 1) begin
      setp(i * 9);
      `CHK("upper_route_a", NORM_TBL[i * 9], upper_route_a);
    end
    $display("normal mode test done");
    wr(`ADDR_LUT_UPPER_LO, EXT_UP, OK);
    wr(`ADDR_LUT_UPPER_HI, EXT_UP, OK);
    wr(`ADDR_LUT_LOWER_LO, EXT_LO, OK);
    wr(`ADDR_LUT_LOWER_HI, EXT_LO, OK);
    wr(`ADDR_CONFIG, {29'h0, `MODE_EXT_LUT}, OK);
    for (i = 0; i < 8; i = i + 1) begin
      nib = i * 2 + 1;
      setp({4'h0, ~i[0], i[1], i[0], nib});
      `CHK("ext out", i[1] ? EXT_LO[{~i[0], nib}] : EXT_UP[{i[0], nib}], upper_route_a);
    end
    $display("extended mode test done");
    wr(`ADDR_CONFIG, 32'h8, OK);
    wr(`ADDR_LUT_UPPER_LO, 32'h0, OK);
    rd(`ADDR_LUT_UPPER_LO, 32'hFFFFFFFF, EXT_UP, OK);
    wr(`ADDR_CONFIG, 32'h0, OK);
    rd(`ADDR_CONFIG, 32'hFFFFFFFF, 32'h0, OK);
    $display("lock test done");
    wr(`ADDR_LUT_UPPER_LO, 32'hFFFFFFFF, OK);
    wr(`ADDR_LUT_UPPER_HI, 32'hFFFFFFFF, OK);
    setp(11'h000);
    rd(`ADDR_STATUS, 32'h4, 32'h4, OK);
    ena <= 1'b0;
    aclr <= 1'b1;
    @(posedge aclk);
    aclr <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(`ADDR_STATUS, 32'h4, 32'h0, OK);
    wr(`ADDR_ROUTE, 32'h1, OK);
    repeat (3) @(posedge aclk);
    `CHK("registered out", 1'b0, upper_route_a);
    wr(`ADDR_ROUTE, 32'h0, OK);
    repeat (3) @(posedge aclk);
    `CHK("bypass out", 1'b1, upper_route_a);
    wr(`ADDR_ROUTE, 32'h100, OK);
    sclr <= 1'b1;
    ena <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(`ADDR_STATUS, 32'h4, 32'h0, OK);
    wr(`ADDR_ROUTE, 32'h0, OK);
    repeat (3) @(posedge aclk);
    rd(`ADDR_STATUS, 32'h4, 32'h4, OK);
    sclr <= 1'b0;
    wr(`ADDR_ROUTE, 32'h400, OK);
    sload <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(`ADDR_STATUS, 32'h4, 32'h0, OK);
    $display("flop control test done");
    // Pre-adder lookups pass a and b, so the cell adds {a,a} + {b,b} + carry_in
    wr(`ADDR_LUT_UPPER_LO, 32'hCCCCAAAA, OK);
    wr(`ADDR_LUT_LOWER_LO, 32'hCCCCAAAA, OK);
    wr(`ADDR_CONFIG, {29'h0, `MODE_ARITH}, OK);
    for (i = 0; i < 8; i = i + 1) begin
      setp({2'h0, i[2], 6'h0, i[1], i[0]});
      `CHK("arith sum", 3 * i[0] + 3 * i[1] + i[2], {carry_out, lower_route_a, upper_route_a});
    end
    $display("arithmetic mode test done");
    conclude;
  end
endmodule // logic_cell_tb
